// [hw/irq_enable_defines.vh]
// register offsets, field positions, masks and reset values of the enable block
`ifndef IRQ_ENABLE_DEFINES_VH
`define IRQ_ENABLE_DEFINES_VH

// byte addresses on the register bus
`define IRQ_EN_GROUP1_ADDR 4'h0
`define IRQ_EN_GROUP2_ADDR 4'h4
`define IRQ_EN_STATUS_ADDR 4'h8
`define IRQ_EN_CONFIG_ADDR 4'hc

// reset values
`define IRQ_EN_GROUP1_RST 16'h0000
`define IRQ_EN_GROUP2_RST 16'h0000
`define IRQ_EN_CONFIG_RST 1'b0

// writable masks, unimplemented positions are zero
`define IRQ_EN_GROUP1_MASK 16'hffdf
`define IRQ_EN_GROUP2_MASK 16'h601f

// group 1 field positions
`define UART_B_TX_IRQ_EN 15
`define UART_B_RX_IRQ_EN 14
`define EXT_PIN_B_IRQ_EN 13
`define TIMER_E_IRQ_EN 12
`define TIMER_D_IRQ_EN 11
`define COMPARE_D_IRQ_EN 10
`define COMPARE_C_IRQ_EN 9
`define DMA_CH_C_DONE_IRQ_EN 8
`define CAPTURE_H_IRQ_EN 7
`define CAPTURE_G_IRQ_EN 6
`define EXT_PIN_A_IRQ_EN 4
`define PIN_CHANGE_IRQ_EN 3
`define COMPARATOR_IRQ_EN 2
`define I2C_MASTER_EVT_IRQ_EN 1
`define I2C_SLAVE_EVT_IRQ_EN 0

// group 2 field positions
`define DMA_CH_E_DONE_IRQ_EN 14
`define PARALLEL_PORT_IRQ_EN 13
`define DMA_CH_D_DONE_IRQ_EN 4
`define CAN_EVENT_IRQ_EN 3
`define CAN_RX_READY_IRQ_EN 2
`define SPI_B_EVENT_IRQ_EN 1
`define SPI_B_ERROR_IRQ_EN 0

// axi response codes
`define AXI_RESP_OKAY 2'b00
`define AXI_RESP_SLVERR 2'b10

`endif

// [hw/irq_en_reg.v]
// one 16-bit enable register with a fixed writable mask and byte strobes
`timescale 1ns/1ps
`default_nettype none

module irq_en_reg #(
  parameter [15:0] MASK = 16'hffff,
  parameter [15:0] RST = 16'h0000
) (
  input wire clk,
  input wire rst,
  input wire wr_en,
  input wire [1:0] wr_strb,
  input wire [15:0] wr_data,
  output wire [15:0] value
);

  reg [15:0] en_q;
  wire [15:0] strb_bits;
  wire [15:0] en_d;

  // merge by lane, then strip positions that do not exist
  assign strb_bits = {{8{wr_strb[1]}}, {8{wr_strb[0]}}};
  assign en_d = ((wr_data & strb_bits) | (en_q & ~strb_bits)) & MASK;

  // unimplemented bits never store, so they always read zero
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      en_q <= RST & MASK;
    end else if (wr_en) begin
      en_q <= en_d;
    end
  end

  assign value = en_q;

endmodule // irq_en_reg

`default_nettype wire

// [hw/irq_gate.v]
// gates pending request flags by their enables, bit for bit
`timescale 1ns/1ps
`default_nettype none

module irq_gate (
  input wire clk,
  input wire rst,
  input wire [15:0] flags,
  input wire [15:0] enables,
  output reg [15:0] req_q
);

  // registered so the arbitration sees a clean, glitch-free level;
  // costs one cycle of request latency
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      req_q <= 16'h0000;
    end else begin
      req_q <= flags & enables;
    end
  end

endmodule // irq_gate

`default_nettype wire

// [hw/irq_enable_regs.v]
// two interrupt enable registers with an axi4-lite slave and request gating
//
// How it works
// - an enable bit of one passes its source's request, zero blocks it
// - group one upper byte: uart b tx/rx, pin b, timers e/d, compares, dma c
// - group one lower byte: captures h/g, spare bit 5, pin a, change, i2c
// - unimplemented bits read zero and ignore writes in both registers
// - group two bit 14 enables dma e done, bit 13 the parallel port
// - group two bit 1 enables spi b event, bit 0 spi b error
// - without the can controller both can requests stay blocked always
//
// The implementer's own choices: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
`include "irq_enable_defines.vh"

module irq_enable_regs (
  input wire clk,
  input wire rst,
  // axi4-lite slave
  input wire [3:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [3:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  // strap: the can controller is fitted
  input wire can_present,
  // pending flags from the sources, same bit layout as the enables
  input wire [15:0] irq_flags_group1,
  input wire [15:0] irq_flags_group2,
  // gated requests toward priority arbitration
  output wire [15:0] irq_req_group1,
  output wire [15:0] irq_req_group2
);

  // bit order of each register is fixed by the field defines
  reg [3:0] aw_addr_q;
  reg aw_have_q;
  reg [31:0] w_data_q;
  reg [3:0] w_strb_q;
  reg w_have_q;
  reg can_sync1_q;
  reg can_sync2_q;
  reg can_present_q;
  reg strap_done_q;
  wire do_write;
  wire wr_g1;
  wire wr_g2;
  wire wr_known;
  wire [15:0] en_g1;
  wire [15:0] en_g2;
  wire [15:0] en_g2_eff;
  // one named wire per enable field, read from the stored registers
  wire uart_b_tx_irq_en;
  wire uart_b_rx_irq_en;
  wire ext_pin_b_irq_en;
  wire timer_e_irq_en;
  wire timer_d_irq_en;
  wire compare_d_irq_en;
  wire compare_c_irq_en;
  wire dma_ch_c_done_irq_en;
  wire capture_h_irq_en;
  wire capture_g_irq_en;
  wire ext_pin_a_irq_en;
  wire pin_change_irq_en;
  wire comparator_irq_en;
  wire i2c_master_evt_irq_en;
  wire i2c_slave_evt_irq_en;
  wire dma_ch_e_done_irq_en;
  wire parallel_port_irq_en;
  wire dma_ch_d_done_irq_en;
  wire can_event_irq_en;
  wire can_rx_ready_irq_en;
  wire spi_b_event_irq_en;
  wire spi_b_error_irq_en;
  wire [15:0] en_g1_eff;
  wire [15:0] status_word;
  reg [31:0] rd_word;
  reg rd_ok;

  // decode one word-aligned address; shared by read and write paths
  function [2:0] decode;
    input [3:0] addr;
    begin
      case (addr)
        `IRQ_EN_GROUP1_ADDR: decode = 3'h1;
        `IRQ_EN_GROUP2_ADDR: decode = 3'h2;
        `IRQ_EN_STATUS_ADDR: decode = 3'h3;
        `IRQ_EN_CONFIG_ADDR: decode = 3'h4;
        default: decode = 3'h0;
      endcase
    end
  endfunction

  // address and data are taken independently, in either order
  assign s_axi_awready = ~aw_have_q & ~s_axi_bvalid;
  assign s_axi_wready = ~w_have_q & ~s_axi_bvalid;
  assign do_write = aw_have_q & w_have_q;
  assign wr_g1 = do_write & (decode(aw_addr_q) == 3'h1);
  assign wr_g2 = do_write & (decode(aw_addr_q) == 3'h2);
  assign wr_known = decode(aw_addr_q) != 3'h0;

  // write channel capture; the write clears both holding slots in the cycle bvalid is raised
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      aw_addr_q <= 4'h0;
      aw_have_q <= 1'b0;
      w_data_q <= 32'h0000_0000;
      w_strb_q <= 4'h0;
      w_have_q <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `AXI_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_addr_q <= s_axi_awaddr;
        aw_have_q <= 1'b1;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
        w_have_q <= 1'b1;
      end
      if (do_write) begin
        aw_have_q <= 1'b0;
        w_have_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_known ? `AXI_RESP_OKAY : `AXI_RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // group 1: bit 5 is the only hole
  irq_en_reg #(
    .MASK(`IRQ_EN_GROUP1_MASK),
    .RST(`IRQ_EN_GROUP1_RST)
  ) u_group1 (
    .clk(clk),
    .rst(rst),
    .wr_en(wr_g1),
    .wr_strb(w_strb_q[1:0]),
    .wr_data(w_data_q[15:0]),
    .value(en_g1)
  );

  // group 2: bit 15 and bits 12..5 are holes
  irq_en_reg #(
    .MASK(`IRQ_EN_GROUP2_MASK),
    .RST(`IRQ_EN_GROUP2_RST)
  ) u_group2 (
    .clk(clk),
    .rst(rst),
    .wr_en(wr_g2),
    .wr_strb(w_strb_q[1:0]),
    .wr_data(w_data_q[15:0]),
    .value(en_g2)
  );

  // strap passes three flops; held off for the first cycle after release
  // so a half-settled strap never reaches the gating
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      can_sync1_q <= 1'b0;
      can_sync2_q <= 1'b0;
      can_present_q <= `IRQ_EN_CONFIG_RST;
      strap_done_q <= 1'b0;
    end else begin
      can_sync1_q <= can_present;
      can_sync2_q <= can_sync1_q;
      strap_done_q <= 1'b1;
      if (!strap_done_q) begin
        can_present_q <= 1'b0;
      end else begin
        can_present_q <= can_sync2_q;
      end
    end
  end

  // field view of group 1; positions come from the field defines
  assign uart_b_tx_irq_en = en_g1[`UART_B_TX_IRQ_EN];
  assign uart_b_rx_irq_en = en_g1[`UART_B_RX_IRQ_EN];
  assign ext_pin_b_irq_en = en_g1[`EXT_PIN_B_IRQ_EN];
  assign timer_e_irq_en = en_g1[`TIMER_E_IRQ_EN];
  assign timer_d_irq_en = en_g1[`TIMER_D_IRQ_EN];
  assign compare_d_irq_en = en_g1[`COMPARE_D_IRQ_EN];
  assign compare_c_irq_en = en_g1[`COMPARE_C_IRQ_EN];
  assign dma_ch_c_done_irq_en = en_g1[`DMA_CH_C_DONE_IRQ_EN];
  assign capture_h_irq_en = en_g1[`CAPTURE_H_IRQ_EN];
  assign capture_g_irq_en = en_g1[`CAPTURE_G_IRQ_EN];
  assign ext_pin_a_irq_en = en_g1[`EXT_PIN_A_IRQ_EN];
  assign pin_change_irq_en = en_g1[`PIN_CHANGE_IRQ_EN];
  assign comparator_irq_en = en_g1[`COMPARATOR_IRQ_EN];
  assign i2c_master_evt_irq_en = en_g1[`I2C_MASTER_EVT_IRQ_EN];
  assign i2c_slave_evt_irq_en = en_g1[`I2C_SLAVE_EVT_IRQ_EN];

  // field view of group 2
  assign dma_ch_e_done_irq_en = en_g2[`DMA_CH_E_DONE_IRQ_EN];
  assign parallel_port_irq_en = en_g2[`PARALLEL_PORT_IRQ_EN];
  assign dma_ch_d_done_irq_en = en_g2[`DMA_CH_D_DONE_IRQ_EN];
  assign can_event_irq_en = en_g2[`CAN_EVENT_IRQ_EN];
  assign can_rx_ready_irq_en = en_g2[`CAN_RX_READY_IRQ_EN];
  assign spi_b_event_irq_en = en_g2[`SPI_B_EVENT_IRQ_EN];
  assign spi_b_error_irq_en = en_g2[`SPI_B_ERROR_IRQ_EN];

  // group 1 gating word rebuilt field by field; bit 5 is a hole
  assign en_g1_eff = {
    uart_b_tx_irq_en,
    uart_b_rx_irq_en,
    ext_pin_b_irq_en,
    timer_e_irq_en,
    timer_d_irq_en,
    compare_d_irq_en,
    compare_c_irq_en,
    dma_ch_c_done_irq_en,
    capture_h_irq_en,
    capture_g_irq_en,
    1'b0,
    ext_pin_a_irq_en,
    pin_change_irq_en,
    comparator_irq_en,
    i2c_master_evt_irq_en,
    i2c_slave_evt_irq_en
  };

  // group 2; without the controller the two can enables are forced off,
  // while the stored bits still read back as written
  assign en_g2_eff = {
    1'b0,
    dma_ch_e_done_irq_en,
    parallel_port_irq_en,
    8'h00,
    dma_ch_d_done_irq_en,
    can_event_irq_en & can_present_q,
    can_rx_ready_irq_en & can_present_q,
    spi_b_event_irq_en,
    spi_b_error_irq_en
  };

  // software still reads back what it wrote; only gating is forced
  irq_gate u_gate1 (
    .clk(clk),
    .rst(rst),
    .flags(irq_flags_group1),
    .enables(en_g1_eff),
    .req_q(irq_req_group1)
  );

  irq_gate u_gate2 (
    .clk(clk),
    .rst(rst),
    .flags(irq_flags_group2),
    .enables(en_g2_eff),
    .req_q(irq_req_group2)
  );

  // status shows what is really being forwarded right now
  assign status_word = irq_req_group1 | irq_req_group2;

  // read mux; unmapped addresses return zero with an error
  always @* begin
    rd_word = 32'h0000_0000;
    rd_ok = 1'b1;
    case (decode(s_axi_araddr))
      3'h1: rd_word = {16'h0000, en_g1};
      3'h2: rd_word = {16'h0000, en_g2};
      3'h3: rd_word = {16'h0000, status_word};
      3'h4: rd_word = {31'h0000_0000, can_present_q};
      default: rd_ok = 1'b0;
    endcase
  end

  assign s_axi_arready = ~s_axi_rvalid;

  // read data registered, held until the master takes it
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `AXI_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_word;
      s_axi_rresp <= rd_ok ? `AXI_RESP_OKAY : `AXI_RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule // irq_enable_regs

`default_nettype wire

// [verif/irq_src_model.sv]
// request sources that feed pending flags to the enable block
`timescale 1ns/1ps
`default_nettype none
module irq_src_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic load,
  input wire logic [31:0] val,
  output logic [15:0] flags1,
  output logic [15:0] flags2
);
  // only the source reloads its flags, the enable block never clears one
  always_ff @(posedge clk or posedge rst) begin
    if (rst)
      {flags2, flags1} <= 32'h0;
    else if (load)
      {flags2, flags1} <= val;
  end
endmodule // irq_src_model
`default_nettype wire

// [verif/irq_enable_regs_checker.sv]
// port assertions for the interrupt enable block
`timescale 1ns/1ps
`default_nettype none
module irq_enable_regs_checker (
  input wire clk,
  input wire rst,
  input wire can_present,
  input wire [15:0] irq_flags_group1,
  input wire [15:0] irq_flags_group2,
  input wire [15:0] irq_req_group1,
  input wire [15:0] irq_req_group2,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire s_axi_rvalid,
  input wire s_axi_rready,
  input wire [31:0] s_axi_rdata
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  logic hi_q;
  // strap latch may only be set once the strap was seen high
  always_ff @(posedge clk or posedge rst) begin
    if (rst)
      hi_q <= 1'b0;
    else if (can_present)
      hi_q <= 1'b1;
  end
  AST_REQ1_SUB:
    assert property (|(irq_req_group1 & ~$past(irq_flags_group1)) == 1'b0)
    else $error("req1 without flag");
  AST_REQ2_SUB:
    assert property (|(irq_req_group2 & ~$past(irq_flags_group2)) == 1'b0)
    else $error("req2 without flag");
  AST_SPARE1:
    assert property ((irq_req_group1 & 16'h0020) == 16'h0000)
    else $error("spare req1 bit");
  AST_SPARE2:
    assert property ((irq_req_group2 & 16'h9fe0) == 16'h0000)
    else $error("spare req2 bit");
  AST_CAN_OFF:
    assert property (!hi_q && !can_present |-> irq_req_group2[3:2] == 2'b00)
    else $error("can req without can");
  AST_RD_HI:
    assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000)
    else $error("upper read bits set");
  AST_RD_LAT:
    assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  AST_R_HOLD:
    assert property (s_axi_rvalid && !s_axi_rready |=>
      s_axi_rvalid && $stable(s_axi_rdata)) else $error("read dropped");
  cover property (s_axi_rvalid && s_axi_rready);
  cover property (irq_req_group1 != 16'h0000);
  cover property (irq_req_group2[3:2] != 2'b00);
endmodule // irq_enable_regs_checker
bind irq_enable_regs irq_enable_regs_checker i_chk (.clk(clk), .rst(rst),
  .can_present(can_present), .irq_flags_group1(irq_flags_group1),
  .irq_flags_group2(irq_flags_group2), .irq_req_group1(irq_req_group1),
  .irq_req_group2(irq_req_group2), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata));
`default_nettype wire

// [verif/test_irq_enable_regs.sv]
// self-checking bench for the interrupt enable block
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, a) begin total_checks++; if ((e) !== (a)) begin fails++; \
  $display("[FAIL] %s exp %h got %h", n, e, a); end end
module test_irq_enable_regs;
  logic clk = 1'b0, rst = 1'b1, can = 1'b0, load = 1'b0;
  logic awv = 1'b0, wv = 1'b0, bready = 1'b0, arv = 1'b0, rready = 1'b0;
  logic [3:0] awaddr = 4'h0, wstrb = 4'h0, araddr = 4'h0;
  logic [31:0] wdata = 32'h0, val = 32'h0, seed = 32'h57;
  wire awready, wready, bvalid, arready, rvalid;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  wire [15:0] f1, f2, q1, q2;
  logic [1:0] bq[$], eb;
  logic [33:0] rq[$], er;
  logic [15:0] e1, e2, x1, x2;
  int fails = 0, total_checks = 0;
  irq_enable_regs i_dut (.clk(clk), .rst(rst), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awv), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wv), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arv), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .can_present(can), .irq_flags_group1(f1),
    .irq_flags_group2(f2), .irq_req_group1(q1), .irq_req_group2(q2));
  irq_src_model i_src (.clk(clk), .rst(rst), .load(load), .val(val),
    .flags1(f1), .flags2(f2));
  always #2.5 clk = ~clk;
  function logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  // write: release each channel at its own handshake, ready late on b
  task wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s);
    logic ad, dd;
    ad = 1'b0;
    dd = 1'b0;
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awv <= 1'b1;
    wv <= 1'b1;
    bq.push_back((a[1:0] != 2'b00) ? 2'b10 : 2'b00);
    while (!(ad && dd)) begin
      @(posedge clk);
      ad = ad | awready;
      dd = dd | wready;
      if (ad) awv <= 1'b0;
      if (dd) wv <= 1'b0;
    end
    do @(posedge clk); while (!bvalid);
    bready <= 1'b1;
    @(posedge clk);
    bready <= 1'b0;
  endtask
  // read: rready raised late so the held answer is exercised
  task rd(input logic [3:0] a, input logic [31:0] e);
    araddr <= a;
    arv <= 1'b1;
    rq.push_back({(a[1:0] != 2'b00) ? 2'b10 : 2'b00, e});
    do @(posedge clk); while (!arready);
    arv <= 1'b0;
    do @(posedge clk); while (!rvalid);
    rready <= 1'b1;
    @(posedge clk);
    rready <= 1'b0;
  endtask
  // monitor pairs each answer with the oldest expectation
  always @(posedge clk) begin
    if (bvalid && bready) begin
      eb = bq.pop_front();
      `CHK("bresp", eb, bresp)
    end
    if (rvalid && rready) begin
      er = rq.pop_front();
      `CHK("rdata", er, {rresp, rdata})
    end
  end
  task run();
    repeat (12) begin
      {e2, e1} = rnd();
      wr(4'h0, {16'h0, e1}, 4'hf);
      wr(4'h4, {16'h0, e2}, 4'hf);
      {x2, x1} = rnd();
      val <= {x2, x1};
      load <= 1'b1;
      @(posedge clk);
      load <= 1'b0;
      repeat (3) @(posedge clk);
      x1 = x1 & e1 & 16'hffdf;
      x2 = x2 & e2 & 16'h601f & (can ? 16'hffff : 16'hfff3);
      `CHK("req1", x1, q1)
      `CHK("req2", x2, q2)
      rd(4'h8, {16'h0, x1 | x2});
    end
    // enable off and on again: flags must have survived
    wr(4'h0, 32'h0, 4'hf);
    wr(4'h0, 32'hffff, 4'hf);
    repeat (2) @(posedge clk);
    `CHK("req1", f1 & 16'hffdf, q1)
  endtask
  task report_and_stop();
    $display("checks %0d fails %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  initial begin
    #20000;
    fails++;
    report_and_stop();
  end
  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd(4'h4, 32'h0);
    wr(4'h0, 32'hffffffff, 4'h3);
    rd(4'h0, 32'hffdf);
    wr(4'h0, 32'h0, 4'h1);
    rd(4'h0, 32'hff00);
    wr(4'h4, 32'hffffffff, 4'hf);
    rd(4'h4, 32'h601f);
    wr(4'h8, 32'hffffffff, 4'hf);
    rd(4'h0, 32'hff00);
    rd(4'hc, 32'h0);
    // unmapped offset: error response, nothing stored
    wr(4'h2, 32'hffffffff, 4'hf);
    rd(4'h2, 32'h0);
    rd(4'h0, 32'hff00);
    run();
    // second reset mid-run, now with the can controller fitted
    rst <= 1'b1;
    can <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    repeat (6) @(posedge clk);
    rd(4'h0, 32'h0);
    rd(4'hc, 32'h1);
    run();
    report_and_stop();
  end
endmodule // test_irq_enable_regs
`default_nettype wire
